// file: logic/ext_bus_pkg.sv
/*
 Package for the external memory bus controller: register addresses,
 reset values, field positions, mode codes and bus cycle counts.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package ext_bus_pkg;
    // Register addresses on the internal special-register bus
    localparam logic [15:0] ADDR_BUS_TYPE = 16'hff8c;
    localparam logic [15:0] ADDR_EXPANSION = 16'hffc4;
    localparam logic [15:0] ADDR_WAIT_CTRL = 16'hffc7;
    // Reset values
    localparam logic [7:0] RST_BUS_TYPE = 8'h00;
    localparam logic [7:0] RST_EXPANSION = 8'h20;
    localparam logic [7:0] RST_WAIT_CTRL = 8'haa;
    // Field positions in the expansion control register
    localparam int FETCH_SPEED_POS = 7;
    localparam int ADDR_WAIT_POS = 5;
    localparam int SIZE_LSB = 0;
    // Writable bits of the expansion control register
    localparam logic [7:0] EXPANSION_MASK = 8'haf;
    // Expansion size codes
    localparam logic [3:0] SIZE_SINGLE = 4'h0;
    localparam logic [3:0] SIZE_256K = 4'h8;
    localparam logic [3:0] SIZE_1M = 4'h9;
    // Wait field codes
    localparam logic [1:0] WAIT_NONE = 2'h0;
    localparam logic [1:0] WAIT_ONE = 2'h1;
    localparam logic [1:0] WAIT_TWO = 2'h2;
    localparam logic [1:0] WAIT_PIN = 2'h3;
    // Base cycle length of an external access, in clocks
    localparam logic [2:0] BASE_CYCLES = 3'h3;
    // Address bits kept in 256 KB mode
    localparam logic [19:0] MASK_256K = 20'h3ffff;
    // Bus cycle phases
    typedef enum logic [2:0] {PH_IDLE, PH_ADDR, PH_AWAIT, PH_DATA, PH_PWAIT, PH_END}
        phase_t;
endpackage : ext_bus_pkg

// file: logic/pin_sync.sv
/*
 Two-flop synchroniser for pin inputs.
 Assumes the input is asynchronous to mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int W = 1
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;
    // First stage read only by second stage
    always_ff @(posedge mclk) begin
        if (srst) begin
            meta_r <= '1;
            q <= '1;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule : pin_sync
`default_nettype wire

// file: logic/ext_bus_ctrl.sv
/*
 External memory bus controller: three control registers, pin role
 assignment for ports 4, 5, 6 and 8, and the external bus cycle sequencer.
 Assumes the CPU core issues one access at a time on the req/ack port and
 that pin buffers combine the _o/_oe/_i triples.
*/
// Contract
// R1: Bus type bit 0 picks multiplexed bus, 1 picks separate buses.
// R2: Multiplexed: port 4 address/data, port 5 middle, port 6 high, strobes on 6.
// R3: Separate: port 4 data only, low address byte on port 8.
// R4: Address strobe still driven on port 6 bit 7 in separate mode.
// R5: Multiplexed mode leaves port 8 as general port pins.
// R6: Wait pin is a plain port pin unless pin wait is selected.
// R7: Expansion control register is 8 bits, resets to 20h.
// R8: Fetch speed bit 1 makes internal fetch fast, ignoring waits.
// R9: Address wait bit adds one clock to the address phase.
// R10: Size 0000 single-chip, 1000 256 KB, 1001 1 MB, others prohibited.
// R11: Bus type register only bit 0 kept, resets to 00h.
// R12: Wait field 00/01/10 gives 3/4/5 cycles, 11 waits on pin low.
// R13: Wait register resets to AAh, bits 7 to 2 ignored.
// R14: Programmed waits apply everywhere except peripheral RAM area.
// R15: Software must not use pin wait for internal ROM fetches.
// R16: Except 1 MB mode, upper address bits are masked before output.
// R17: External latch captures address on address strobe before data.
// R18: Memory holds wait pin low until ready, then releases high.
`timescale 1ns/1ps
`default_nettype none
module ext_bus_ctrl (
    input wire logic mclk,
    input wire logic srst,
    // Special-register access
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_hit,
    // CPU access request
    input wire logic acc_req,
    input wire logic acc_we,
    input wire logic acc_irom,
    input wire logic acc_pram,
    input wire logic [19:0] acc_addr,
    input wire logic [7:0] acc_wdata,
    output logic acc_ack,
    output logic [7:0] acc_rdata,
    // Port latches for pins in port role
    input wire logic [7:0] p4_port,
    input wire logic [7:0] p5_port,
    input wire logic [7:0] p6_port,
    input wire logic [7:0] p8_port,
    input wire logic [7:0] p4_port_oe,
    input wire logic [7:0] p5_port_oe,
    input wire logic [7:0] p6_port_oe,
    input wire logic [7:0] p8_port_oe,
    // Pins
    input wire logic [7:0] p4_i,
    input wire logic [7:0] p6_i,
    output logic [7:0] p4_o,
    output logic [7:0] p4_oe,
    output logic [7:0] p5_o,
    output logic [7:0] p5_oe,
    output logic [7:0] p6_o,
    output logic [7:0] p6_oe,
    output logic [7:0] p8_o,
    output logic [7:0] p8_oe,
    // Mode status
    output logic size_prohibited
);
    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic bus_type_r;
    logic [7:0] expansion_r;
    logic [7:0] wait_ctrl_r;
    wire sel_bt = reg_addr == ext_bus_pkg::ADDR_BUS_TYPE;
    wire sel_ex = reg_addr == ext_bus_pkg::ADDR_EXPANSION;
    wire sel_wc = reg_addr == ext_bus_pkg::ADDR_WAIT_CTRL;
    assign reg_hit = sel_bt | sel_ex | sel_wc;

    // Register writes; unused bus type and expansion bits kept at zero, wait control bits 7 to 2 stored as written
    always_ff @(posedge mclk) begin
        if (srst) begin
            bus_type_r <= ext_bus_pkg::RST_BUS_TYPE[0]; // see R11
            expansion_r <= ext_bus_pkg::RST_EXPANSION; // see R7
            wait_ctrl_r <= ext_bus_pkg::RST_WAIT_CTRL; // see R13
        end else if (reg_wr) begin
            if (sel_bt) bus_type_r <= reg_wdata[0]; // see R11
            if (sel_ex) expansion_r <= reg_wdata & ext_bus_pkg::EXPANSION_MASK; // see R7
            if (sel_wc) wait_ctrl_r <= reg_wdata;
        end
    end

    // Read mux; unmapped addresses read zero
    always_ff @(posedge mclk) begin
        if (srst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= sel_bt ? {7'h00, bus_type_r} :
                         sel_ex ? expansion_r :
                         sel_wc ? wait_ctrl_r : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode decode
    wire separate = bus_type_r; // see R1
    wire fast_fetch = expansion_r[ext_bus_pkg::FETCH_SPEED_POS];
    wire addr_wait = expansion_r[ext_bus_pkg::ADDR_WAIT_POS];
    wire [3:0] size = expansion_r[ext_bus_pkg::SIZE_LSB +: 4];
    wire [1:0] wfield = wait_ctrl_r[1:0]; // see R13
    wire mode_256k = size == ext_bus_pkg::SIZE_256K; // see R10
    wire mode_1m = size == ext_bus_pkg::SIZE_1M; // see R10
    // Prohibited codes behave as single-chip so no pin is taken
    wire expanded = mode_256k | mode_1m;
    assign size_prohibited = !expanded && size != ext_bus_pkg::SIZE_SINGLE; // see R10
    wire pin_wait = expanded && wfield == ext_bus_pkg::WAIT_PIN;

    ////////////////////////////////////////////////////////////////////////
    // Wait pin synchronised before any logic reads it
    logic wait_pin_s;
    pin_sync #(.W(1)) u_wait_sync (
        .mclk(mclk),
        .srst(srst),
        .d(p6_i[6]),
        .q(wait_pin_s)
    );
    logic [7:0] p4_s;
    pin_sync #(.W(8)) u_data_sync (
        .mclk(mclk),
        .srst(srst),
        .d(p4_i),
        .q(p4_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // Bus cycle sequencer
    ext_bus_pkg::phase_t ph_r, ph_nxt;
    logic [1:0] wcnt_r, wcnt_nxt;
    logic [19:0] addr_r;
    logic we_r;
    logic [7:0] wdata_r;
    logic [1:0] nwait_r;
    logic pinw_r;
    logic rd_cap_r;
    // Fast internal fetch skips the bus and all waits
    wire fast_path = acc_irom && fast_fetch; // see R8
    // Peripheral RAM takes no programmed waits
    wire [1:0] prog_waits = (acc_pram || wfield == ext_bus_pkg::WAIT_PIN) ? 2'h0 : wfield; // see R14
    // Upper address masked except in 1 MB mode
    wire [19:0] out_addr = mode_1m ? acc_addr : (acc_addr & ext_bus_pkg::MASK_256K); // see R16

    // Phase sequencing: addr, optional address wait, data, waits, end
    always_comb begin
        ph_nxt = ph_r;
        wcnt_nxt = wcnt_r;
        case (ph_r)
            ext_bus_pkg::PH_IDLE: begin
                if (acc_req && !fast_path) ph_nxt = ext_bus_pkg::PH_ADDR;
            end
            ext_bus_pkg::PH_ADDR: begin
                ph_nxt = addr_wait ? ext_bus_pkg::PH_AWAIT : ext_bus_pkg::PH_DATA; // see R9
            end
            ext_bus_pkg::PH_AWAIT: ph_nxt = ext_bus_pkg::PH_DATA;
            ext_bus_pkg::PH_DATA: begin
                wcnt_nxt = 2'h0;
                if (nwait_r != 2'h0 || pinw_r) ph_nxt = ext_bus_pkg::PH_PWAIT;
                else ph_nxt = ext_bus_pkg::PH_END;
            end
            ext_bus_pkg::PH_PWAIT: begin
                // Saturates so a long pin wait never wraps back to zero
                if (wcnt_r != 2'h3) wcnt_nxt = wcnt_r + 2'h1;
                // Pin wait stretches while low; first synced sample predates the strobe
                if (pinw_r) begin
                    if (wcnt_r != 2'h0 && wait_pin_s) begin
                        ph_nxt = ext_bus_pkg::PH_END; // see R12, R18
                    end
                end else if (wcnt_nxt == nwait_r) begin
                    ph_nxt = ext_bus_pkg::PH_END; // see R12
                end
            end
            ext_bus_pkg::PH_END: ph_nxt = ext_bus_pkg::PH_IDLE;
            default: ph_nxt = ext_bus_pkg::PH_IDLE;
        endcase
    end

    // Phase state and captured request
    always_ff @(posedge mclk) begin
        if (srst) begin
            ph_r <= ext_bus_pkg::PH_IDLE;
            wcnt_r <= 2'h0;
            addr_r <= 20'h00000;
            we_r <= 1'b0;
            wdata_r <= 8'h00;
            nwait_r <= 2'h0;
            pinw_r <= 1'b0;
        end else begin
            ph_r <= ph_nxt;
            wcnt_r <= wcnt_nxt;
            if (ph_r == ext_bus_pkg::PH_IDLE && acc_req) begin
                addr_r <= out_addr;
                we_r <= acc_we;
                wdata_r <= acc_wdata;
                nwait_r <= prog_waits;
                pinw_r <= pin_wait && !acc_pram; // see R14, R15
            end
        end
    end

    // Read data taken a clock after the cycle closes: the synchroniser
    // lags two clocks, so this is the last sample under the read strobe
    always_ff @(posedge mclk) begin
        if (srst) begin
            rd_cap_r <= 1'b0;
            acc_rdata <= 8'h00;
        end else begin
            rd_cap_r <= ph_r == ext_bus_pkg::PH_END && !we_r;
            if (rd_cap_r) acc_rdata <= p4_s;
        end
    end

    assign acc_ack = (ph_r == ext_bus_pkg::PH_END) ||
                     (ph_r == ext_bus_pkg::PH_IDLE && acc_req && fast_path); // see R8

    ////////////////////////////////////////////////////////////////////////
    // Strobes and pin roles
    wire in_addr = ph_r == ext_bus_pkg::PH_ADDR || ph_r == ext_bus_pkg::PH_AWAIT;
    wire in_data = ph_r == ext_bus_pkg::PH_DATA || ph_r == ext_bus_pkg::PH_PWAIT;
    wire address_strobe = ph_r == ext_bus_pkg::PH_ADDR; // see R4, R17
    wire rd_n = !(in_data && !we_r);
    wire wr_n = !(in_data && we_r);
    wire [7:0] bus_p4 = (in_addr && !separate) ? addr_r[7:0] : wdata_r; // see R2, R3
    wire bus_p4_oe = (in_addr && !separate) || (in_data && we_r);
    wire [3:0] hi_lines = mode_1m ? 4'hf : 4'h3; // see R10
    wire [7:0] p6_bus = {address_strobe, 1'b1, wr_n, rd_n, addr_r[19:16]};
    // Port 6 bus roles: high lines, RD, WR, ADDRESS_STROBE; wait pin only when pin wait
    wire [7:0] p6_role = expanded ? {2'b10, 2'b11, hi_lines} : 8'h00; // see R2, R6
    wire p8_addr = expanded && separate; // see R3, R5

    assign p4_o = expanded ? bus_p4 : p4_port;
    assign p4_oe = expanded ? {8{bus_p4_oe}} : p4_port_oe;
    assign p5_o = expanded ? addr_r[15:8] : p5_port; // see R2
    assign p5_oe = expanded ? 8'hff : p5_port_oe;
    assign p6_o = (p6_role & p6_bus) | (~p6_role & p6_port);
    assign p6_oe = p6_role | (~p6_role & p6_port_oe & {1'b1, ~pin_wait, 6'h3f}); // see R6
    assign p8_o = p8_addr ? addr_r[7:0] : p8_port;
    assign p8_oe = p8_addr ? 8'hff : p8_port_oe; // see R5

    ////////////////////////////////////////////////////////////////////////
    // Checks
    // Reset checked one clock on, once the registers have taken it
    AST_RESET_VALUES: assert property (@(posedge mclk) // see R7
        srst |=> expansion_r == ext_bus_pkg::RST_EXPANSION
        && wait_ctrl_r == ext_bus_pkg::RST_WAIT_CTRL && !bus_type_r)
        else $error("reset values wrong");
    AST_BT_ZERO: assert property (@(posedge mclk) disable iff (srst) // see R11
        reg_rd && sel_bt |=> reg_rdata[7:1] == 7'h00)
        else $error("bus type upper bits not zero");
    AST_P8_PORT: assert property (@(posedge mclk) disable iff (srst) // see R5
        !separate |-> p8_o == p8_port && p8_oe == p8_port_oe)
        else $error("port 8 taken in multiplexed mode");
    AST_MASK: assert property (@(posedge mclk) disable iff (srst) // see R16
        ph_r != ext_bus_pkg::PH_IDLE && !mode_1m |-> addr_r[19:18] == 2'b00)
        else $error("address not masked");
    AST_FAST: assert property (@(posedge mclk) disable iff (srst) // see R8
        ph_r == ext_bus_pkg::PH_IDLE && acc_req && acc_irom && fast_fetch |-> acc_ack)
        else $error("fast fetch not immediate");
    // Request edge, then address, data, two waits, end: ack five clocks on
    AST_CYCLE_LEN: assert property (@(posedge mclk) disable iff (srst) // see R12
        ph_r == ext_bus_pkg::PH_IDLE && acc_req && !fast_path && !addr_wait
        && prog_waits == 2'h2 && !pin_wait |-> ##5 acc_ack)
        else $error("two-wait cycle not five clocks");
    AST_ADDR_WAIT: assert property (@(posedge mclk) disable iff (srst) // see R9
        ph_r == ext_bus_pkg::PH_ADDR && addr_wait |=> ph_r == ext_bus_pkg::PH_AWAIT)
        else $error("address wait missing");
    AST_ADDRESS_STROBE_SEP: assert property (@(posedge mclk) disable iff (srst) // see R4
        expanded && separate && address_strobe |-> p6_o[7] && p6_oe[7])
        else $error("strobe not driven in separate mode");
    AST_SINGLE: assert property (@(posedge mclk) disable iff (srst) // see R10
        !expanded |-> p5_o == p5_port && p6_o == p6_port)
        else $error("pins taken in single-chip mode");
    COV_MUX: cover property (@(posedge mclk) address_strobe && !separate && expanded);
    COV_SEP: cover property (@(posedge mclk) address_strobe && separate && expanded);
    COV_PINW: cover property (@(posedge mclk) ph_r == ext_bus_pkg::PH_PWAIT && pinw_r);
endmodule : ext_bus_ctrl
`default_nettype wire

// file: sim/ext_mem_model.sv
/*
 Behavioural external memory with an address latch, for the bus controller.
 Assumes active-low read/write strobes on p6 bits 4 and 5, address strobe on bit 7.
*/
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
    input wire logic mclk,
    input wire logic sep,
    input wire logic [3:0] wait_len,
    input wire logic [7:0] p4_o,
    input wire logic [7:0] p6_o,
    input wire logic [7:0] p8_o,
    output logic [7:0] p4_i,
    output logic [7:0] p6_i
);
    logic [7:0] mem [256];
    logic [7:0] lat = 8'h00;
    logic [7:0] last = 8'h00;
    logic [3:0] wcnt = 4'h0;
    wire logic idle = p6_o[4] & p6_o[5];
    wire logic [7:0] a = sep ? p8_o : lat;
    // Transparent latch on the shared bus while address strobe is high
    always @* if (p6_o[7]) lat = p4_o;
    // Undriven bus shows a changing pattern, never the last value
    assign p4_i = !p6_o[4] ? mem[a] : ~last;
    assign p6_i = {~last[7], idle | (wcnt == 4'h0), ~last[5:0]};
    // Wait held low for wait_len clocks after a strobe falls
    always @(posedge mclk) begin
        last <= p4_i;
        if (idle) wcnt <= wait_len;
        else if (wcnt != 4'h0) wcnt <= wcnt - 4'h1;
        if (!p6_o[5]) mem[a] <= p4_o;
    end
endmodule : ext_mem_model
`default_nettype wire

// file: sim/external_memory_bus_control_tb.sv
/*
 Self-checking bench for ext_bus_ctrl with an external memory model.
 Assumes the package constants and the hand-over timing of req/ack.
*/
`timescale 1ns/1ps
`default_nettype none
module external_memory_bus_control_tb;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic [15:0] reg_addr = 16'h0000;
    logic reg_wr = 1'b0, reg_rd = 1'b0, sep = 1'b0;
    logic [7:0] reg_wdata = 8'h00, acc_wdata = 8'h00, pv = 8'h3c, po = 8'h5a;
    logic acc_req = 1'b0, acc_we = 1'b0, acc_irom = 1'b0, acc_pram = 1'b0;
    logic [19:0] acc_addr = 20'h00000;
    logic [3:0] wait_len = 4'h0;
    logic [7:0] reg_rdata, acc_rdata, p4_i, p6_i, p4_o, p4_oe, p5_o, p5_oe;
    logic [7:0] p6_o, p6_oe, p8_o, p8_oe, rdat;
    logic reg_hit, acc_ack, size_prohibited, address_strobe_seen;
    logic [11:0] hi_addr;
    int err_total = 0, tests_run = 0, n;
    always #5 mclk = ~mclk;
    ext_bus_ctrl DUT (.mclk(mclk), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
        .acc_req(acc_req), .acc_we(acc_we), .acc_irom(acc_irom), .acc_pram(acc_pram),
        .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_ack(acc_ack),
        .acc_rdata(acc_rdata), .p4_port(pv), .p5_port(~pv), .p6_port(pv), .p8_port(~pv),
        .p4_port_oe(po), .p5_port_oe(~po), .p6_port_oe(po), .p8_port_oe(~po),
        .p4_i(p4_i), .p6_i(p6_i), .p4_o(p4_o), .p4_oe(p4_oe), .p5_o(p5_o), .p5_oe(p5_oe),
        .p6_o(p6_o), .p6_oe(p6_oe), .p8_o(p8_o), .p8_oe(p8_oe),
        .size_prohibited(size_prohibited));
    ext_mem_model mem_i (.mclk(mclk), .sep(sep), .wait_len(wait_len), .p4_o(p4_o),
        .p6_o(p6_o), .p8_o(p8_o), .p4_i(p4_i), .p6_i(p6_i));
    ////////////////////////////////////////////////////////////////////////////////
    // Shared compare, register and access tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask : rd
    // Holds the request until ack is seen; counts cycles, captures high address
    task automatic acc(input logic we, ir, pr, input logic [19:0] a, input logic [7:0] d);
        @(posedge mclk);
        {acc_req, acc_we, acc_irom, acc_pram, acc_addr, acc_wdata} <= {1'b1, we, ir, pr, a, d};
        address_strobe_seen = 1'b0;
        n = 0;
        #1;
        while (acc_ack !== 1'b1 && n < 60) begin
            @(posedge mclk);
            #1 n++;
            if (p6_o[7] === 1'b1) begin
                address_strobe_seen = 1'b1;
                hi_addr = {p6_o[3:0], p5_o};
            end
        end
        @(posedge mclk);
        acc_req <= 1'b0;
        // Read data lands one clock after the ack edge
        @(posedge mclk);
        #1 rdat = acc_rdata;
    endtask : acc
    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_regs;
        rd(16'hff8c, 8'h00);
        rd(16'hffc4, 8'h20);
        rd(16'hffc7, 8'haa);
        rd(16'hff00, 8'h00);
        wr(16'hff8c, 8'hff);
        rd(16'hff8c, 8'h01);
        wr(16'hffc4, 8'hff);
        rd(16'hffc4, 8'haf);
        chk(size_prohibited, 1'b1);
        chk({p4_oe, p5_o, p6_oe, p8_o}, {po, ~pv, po, ~pv});
        wr(16'hff8c, 8'h00);
        wr(16'hffc4, 8'h00);
        pv <= 8'hc3;
        #20 chk({p4_o, p5_oe, p6_o, p8_oe}, {pv, ~po, pv, ~po});
    endtask : t_regs
    task automatic t_mux;
        wr(16'hffc4, 8'h09);
        for (int aw = 0; aw < 2; aw++) begin
            for (int w = 0; w < 3; w++) begin
                wr(16'hffc4, {2'b00, aw[0], 5'h09});
                wr(16'hffc7, {6'h00, w[1:0]});
                acc(1'b1, 1'b0, 1'b0, 20'h54355, 8'ha7);
                chk(n, 3 + aw + w);
                chk(hi_addr, 12'h543);
            end
        end
        chk({p8_oe, p6_oe[6], p6_o[6]}, {~po, po[6], pv[6]});
        // Zero-wait read is the tightest data window
        wr(16'hffc7, 8'h00);
        acc(1'b0, 1'b0, 1'b0, 20'h54355, 8'h00);
        chk(rdat, 8'ha7);
        chk(n, 4);
    endtask : t_mux
    task automatic t_sep;
        wr(16'hffc4, 8'h08);
        acc(1'b0, 1'b0, 1'b0, 20'h54355, 8'h00);
        chk(hi_addr[9:0], 10'h143);
        chk(p6_oe[3:2], po[3:2]);
        wr(16'hff8c, 8'h01);
        sep <= 1'b1;
        acc(1'b0, 1'b0, 1'b0, 20'h54355, 8'h00);
        chk({address_strobe_seen, rdat}, {1'b1, 8'ha7});
        wr(16'hff8c, 8'h00);
        sep <= 1'b0;
    endtask : t_sep
    task automatic t_speed;
        wr(16'hffc7, 8'h02);
        wr(16'hffc4, 8'h89);
        acc(1'b0, 1'b1, 1'b0, 20'h00100, 8'h00);
        chk(n, 0);
        wr(16'hffc4, 8'h09);
        acc(1'b0, 1'b1, 1'b0, 20'h00100, 8'h00);
        chk(n, 5);
        acc(1'b0, 1'b0, 1'b1, 20'h00200, 8'h00);
        chk(n, 3);
        // Pin wait only on external space, never internal ROM
        wr(16'hffc7, 8'h03);
        wait_len <= 4'h4;
        acc(1'b0, 1'b0, 1'b0, 20'h54355, 8'h00);
        chk(n >= 7 && n <= 12, 1'b1);
        chk(rdat, 8'ha7);
    endtask : t_speed
    ////////////////////////////////////////////////////////////////////////////////
    // Verdict, watchdog and main sequence
    task automatic give_verdict;
        $display("checks=%0d mismatches=%0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict
    initial begin
        #100000;
        err_total++;
        give_verdict();
    end
    initial begin
        repeat (16) @(posedge mclk);
        srst <= 1'b0;
        t_regs();
        t_mux();
        t_sep();
        t_speed();
        give_verdict();
    end
endmodule : external_memory_bus_control_tb
`default_nettype wire
